/* hw/dma_chan_status.v */
// per-channel dma status vectors with apb control and event interrupt
// assumes engine event inputs come from logic on pclk, pclk at 100 MHz
//
// Functional notes
// - one status vector per dma channel
// - bit 6 mirrors channel run control bit
// - bit 5 high while interrupt pending
// - bit 4 flags stream end-of-packet beat posted
// - bit 3 flags descriptor finished, whatever its flags
// - bit 2 descriptor finished with stop flag
// - bit 1 descriptor finished with completed flag
// - bit 0 buffer nonempty or requests outstanding
`include "chan_status_regs.vh"

module dma_chan_status (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // engine events, one bit per channel
  input wire [3:0] desc_push,
  input wire [3:0] req_issue,
  input wire [3:0] req_retire,
  input wire [3:0] desc_finish,
  input wire [3:0] desc_stop_flag,
  input wire [3:0] desc_cmpl_flag,
  input wire [3:0] eop_posted,
  input wire [3:0] stream_mode,
  input wire [3:0] irq_raise,
  // status vectors to user logic
  output reg [6:0] chan0_status,
  output reg [6:0] chan1_status,
  output reg [6:0] chan2_status,
  output reg [6:0] chan3_status,
  // event interrupt
  output reg irq
);

  localparam NC = `NUM_CHAN;
  localparam EW = NC * `EV_PER_CHAN;
  localparam [31:0] CTRL_RST_W = `CTRL_RST;
  localparam [31:0] MASK_RST_W = `MASK_RST;

  function is_addr;
    input [11:0] a;
    input [11:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  reg [NC-1:0] run;
  reg [NC-1:0] irq_pend;
  reg [EW-1:0] ev_mask;
  wire [NC-1:0] busy;
  wire [NC-1:0] d_done;
  wire [NC-1:0] d_stop;
  wire [NC-1:0] d_cmpl;
  wire [NC-1:0] p_done;
  wire [EW-1:0] ev_vec;
  wire [EW-1:0] ev_status;
  wire ev_irq;
  wire [`STAT_W*NC-1:0] vec_flat;

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire in_vec = (paddr >= `OFF_VEC0) && (paddr < (`OFF_VEC0 + 12'h010)) && (paddr[1:0] == 2'b00);
  wire mapped = is_addr(paddr, `OFF_CTRL) || is_addr(paddr, `OFF_STATUS) ||
                is_addr(paddr, `OFF_EVENT) || is_addr(paddr, `OFF_MASK) ||
                is_addr(paddr, `OFF_IRQ_PEND) || is_addr(paddr, `OFF_IRQ_SET) || in_vec;

  genvar g;
  generate
    for (g = 0; g < NC; g = g + 1) begin : ch
      chan_desc_tracker u_trk (
        .pclk(pclk),
        .presetn(presetn),
        .run(run[g]),
        .desc_push(desc_push[g]),
        .req_issue(req_issue[g]),
        .req_retire(req_retire[g]),
        .desc_finish(desc_finish[g]),
        .desc_stop_flag(desc_stop_flag[g]),
        .desc_cmpl_flag(desc_cmpl_flag[g]),
        .eop_posted(eop_posted[g]),
        .stream_mode(stream_mode[g]),
        .busy(busy[g]),
        .desc_done(d_done[g]),
        .desc_stop(d_stop[g]),
        .desc_completed(d_cmpl[g]),
        .pkt_done(p_done[g])
      );
      assign ev_vec[g*`EV_PER_CHAN+`EV_DESC_DONE] = d_done[g];
      assign ev_vec[g*`EV_PER_CHAN+`EV_DESC_STOP] = d_stop[g];
      assign ev_vec[g*`EV_PER_CHAN+`EV_DESC_COMPLETED] = d_cmpl[g];
      assign ev_vec[g*`EV_PER_CHAN+`EV_PKT_DONE] = p_done[g];
      // vector assembly per channel
      assign vec_flat[g*`STAT_W+`BIT_RUN] = run[g];
      assign vec_flat[g*`STAT_W+`BIT_IRQ_PEND] = irq_pend[g];
      assign vec_flat[g*`STAT_W+`BIT_PKT_DONE] = p_done[g];
      assign vec_flat[g*`STAT_W+`BIT_DESC_DONE] = d_done[g];
      assign vec_flat[g*`STAT_W+`BIT_DESC_STOP] = d_stop[g];
      assign vec_flat[g*`STAT_W+`BIT_DESC_COMPLETED] = d_cmpl[g];
      assign vec_flat[g*`STAT_W+`BIT_BUSY] = busy[g];
    end
  endgenerate

  // clear on the edge that latches prdata, so an event landing there is kept, not lost unread
  wire ev_rd = rd && !pready && is_addr(paddr, `OFF_EVENT);

  irq_sticky #(
    .W(EW)
  ) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .event_in(ev_vec),
    .mask(ev_mask),
    .clear_rd(ev_rd),
    .status(ev_status),
    .irq(ev_irq)
  );

  // pending interrupt per channel: hardware raise wins over software clear
  wire [NC-1:0] pend_clr = (wr && pready && is_addr(paddr, `OFF_IRQ_PEND)) ? pwdata[NC-1:0] : {NC{1'b0}};
  wire [NC-1:0] pend_set = (wr && pready && is_addr(paddr, `OFF_IRQ_SET)) ? pwdata[NC-1:0] : {NC{1'b0}};

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    if (is_addr(paddr, `OFF_CTRL))
      rd_mux[NC-1:0] = run;
    else if (is_addr(paddr, `OFF_STATUS))
      rd_mux[NC-1:0] = busy;
    else if (is_addr(paddr, `OFF_EVENT))
      rd_mux[EW-1:0] = ev_status;
    else if (is_addr(paddr, `OFF_MASK))
      rd_mux[EW-1:0] = ev_mask;
    else if (is_addr(paddr, `OFF_IRQ_PEND))
      rd_mux[NC-1:0] = irq_pend;
    else if (in_vec)
      rd_mux[`STAT_W-1:0] = vec_flat[paddr[3:2]*`STAT_W +: `STAT_W];
  end

  // apb: setup then one wait cycle, answer on second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      run <= CTRL_RST_W[NC-1:0];
      ev_mask <= MASK_RST_W[EW-1:0];
      irq_pend <= {NC{1'b0}};
    end else begin
      pready <= acc && !pready;
      prdata <= (acc && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= acc && !pready && !mapped;
      if (wr && pready && is_addr(paddr, `OFF_CTRL))
        run <= pwdata[NC-1:0];
      if (wr && pready && is_addr(paddr, `OFF_MASK))
        ev_mask <= pwdata[EW-1:0];
      irq_pend <= (irq_pend & ~pend_clr) | pend_set | irq_raise;
    end
  end

  // status outputs registered on pclk, zero under reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan0_status <= 7'h00;
      chan1_status <= 7'h00;
      chan2_status <= 7'h00;
      chan3_status <= 7'h00;
      irq <= 1'b0;
    end else begin
      chan0_status <= vec_flat[0*`STAT_W +: `STAT_W];
      chan1_status <= vec_flat[1*`STAT_W +: `STAT_W];
      chan2_status <= vec_flat[2*`STAT_W +: `STAT_W];
      chan3_status <= vec_flat[3*`STAT_W +: `STAT_W];
      irq <= ev_irq;
    end
  end

endmodule

/* hw/chan_status_regs.vh */
// constants for the per-channel dma status vector block
// assumes a 32-bit apb register bus and a 100 MHz pclk
`ifndef CHAN_STATUS_REGS_VH
`define CHAN_STATUS_REGS_VH

`define NUM_CHAN 4
`define STAT_W 7

// status vector bit positions
`define BIT_BUSY 0
`define BIT_DESC_COMPLETED 1
`define BIT_DESC_STOP 2
`define BIT_DESC_DONE 3
`define BIT_PKT_DONE 4
`define BIT_IRQ_PEND 5
`define BIT_RUN 6

// register byte offsets
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_EVENT 12'h008
`define OFF_MASK 12'h00c
`define OFF_IRQ_PEND 12'h010
`define OFF_IRQ_SET 12'h014
`define OFF_VEC0 12'h020

// reset values
`define CTRL_RST 32'h0000_0000
`define MASK_RST 32'h0000_0000

// event status layout: per channel, desc_done/stop/completed/pkt_done
`define EV_PER_CHAN 4
`define EV_DESC_DONE 0
`define EV_DESC_STOP 1
`define EV_DESC_COMPLETED 2
`define EV_PKT_DONE 3

`endif

/* hw/chan_desc_tracker.v */
// one channel's descriptor engine status model
// assumes event pulses come from logic on pclk
`include "chan_status_regs.vh"

module chan_desc_tracker (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire run,
  // engine events
  input wire desc_push,
  input wire req_issue,
  input wire req_retire,
  input wire desc_finish,
  input wire desc_stop_flag,
  input wire desc_cmpl_flag,
  input wire eop_posted,
  input wire stream_mode,
  // results
  output reg busy,
  output reg desc_done,
  output reg desc_stop,
  output reg desc_completed,
  output reg pkt_done
);

  reg [4:0] buf_count;
  reg [7:0] req_count;
  wire [4:0] next_buf_count;
  wire [7:0] next_req_count;

  assign next_buf_count = buf_count + {4'h0, desc_push} - {4'h0, desc_finish};
  assign next_req_count = req_count + {7'h00, req_issue} - {7'h00, req_retire};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_count <= 5'h00;
      req_count <= 8'h00;
      busy <= 1'b0;
      desc_done <= 1'b0;
      desc_stop <= 1'b0;
      desc_completed <= 1'b0;
      pkt_done <= 1'b0;
    end else begin
      buf_count <= next_buf_count;
      req_count <= next_req_count;
      busy <= (next_buf_count != 5'h00) || (next_req_count != 8'h00);
      desc_done <= desc_finish;
      desc_stop <= desc_finish && desc_stop_flag;
      desc_completed <= desc_finish && desc_cmpl_flag;
      pkt_done <= stream_mode && eop_posted;
    end
  end

endmodule

/* hw/irq_sticky.v */
// sticky event bits with read-to-clear and mask
// assumes events and the read strobe are on pclk
`include "chan_status_regs.vh"

module irq_sticky #(
  parameter W = 16
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // events and software access
  input wire [W-1:0] event_in,
  input wire [W-1:0] mask,
  input wire clear_rd,
  // results
  output reg [W-1:0] status,
  output reg irq
);

  wire [W-1:0] next_status;
  assign next_status = (clear_rd ? {W{1'b0}} : status) | event_in;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= {W{1'b0}};
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(next_status & mask);
    end
  end

endmodule

/* verification/dma_chan_status_asserts.sv */
// port-level checks of the per-channel status vectors
// assumes one pclk domain and presetn asynchronous active low
module dma_chan_status_asserts (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // engine events
  input wire logic [3:0] req_issue,
  input wire logic [3:0] desc_finish,
  input wire logic [3:0] eop_posted,
  input wire logic [3:0] stream_mode,
  input wire logic [3:0] irq_raise,
  // status vectors
  input wire logic [6:0] chan0_status,
  input wire logic [6:0] chan1_status,
  input wire logic [6:0] chan2_status,
  input wire logic [6:0] chan3_status
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_reset_zero: assert property (disable iff (1'b0) !presetn |-> chan0_status == 7'h00)
    else $error("status not zero in reset");
  chk_run_follows: assert property (psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[0]
    |-> ##[1:4] chan0_status[6]) else $error("run bit not mirrored");
  chk_irq_pend: assert property (irq_raise[0] |-> ##[1:4] chan0_status[5])
    else $error("pending bit missing");
  chk_pkt_done: assert property (eop_posted[0] && stream_mode[0] |-> ##[1:4] chan0_status[4])
    else $error("packet done missing");
  chk_desc_done: assert property (desc_finish[0] |-> ##[1:4] chan0_status[3])
    else $error("descriptor done missing");
  chk_stop_cause: assert property ($rose(chan2_status[2]) |-> chan2_status[3])
    else $error("stop without done");
  chk_cmpl_cause: assert property (chan1_status[1] |-> chan1_status[3])
    else $error("completed without done");
  chk_busy_issue: assert property (req_issue[3] |-> ##[1:4] chan3_status[0])
    else $error("busy missing");
  chk_unmapped_err: assert property (psel && penable && pready && paddr == 12'h030 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule

bind dma_chan_status dma_chan_status_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .req_issue, .desc_finish, .eop_posted, .stream_mode, .irq_raise,
  .chan0_status, .chan1_status, .chan2_status, .chan3_status);

/* verification/status_monitor.sv */
// user-side monitor: remembers every status bit seen since the last clear
// assumes status vectors are registered on pclk
module status_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // clear and observed vectors
  input wire logic clr,
  input wire logic [27:0] stat,
  output logic [27:0] seen
);
  timeunit 1ns;
  timeprecision 1ns;
  // one-cycle pulses are caught here so the bench need not hit the exact cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) seen <= 28'h0;
    else seen <= clr ? 28'h0 : (seen | stat);
  end
endmodule

/* verification/testbench.sv */
// self-checking bench for the per-channel status vectors
// assumes the design answers apb with pready and a 100 MHz pclk
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, clr = 0, slv;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, evt = 0, rd;
  logic [3:0] smode = 0;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  wire [6:0] s0, s1, s2, s3;
  wire [27:0] seen;
  int err_total = 0, compares = 0;
  always #5 pclk = ~pclk;
  // evt: push, issue, retire, finish, stop, completed, eop, irq raise, four bits each
  dma_chan_status dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .desc_push(evt[3:0]), .req_issue(evt[7:4]), .req_retire(evt[11:8]), .desc_finish(evt[15:12]),
    .desc_stop_flag(evt[19:16]), .desc_cmpl_flag(evt[23:20]), .eop_posted(evt[27:24]), .stream_mode(smode),
    .irq_raise(evt[31:28]), .chan0_status(s0), .chan1_status(s1), .chan2_status(s2), .chan3_status(s3), .irq);
  status_monitor mon (.pclk, .presetn, .clr, .stat({s3, s2, s1, s0}), .seen);
  task chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task ev(input logic [31:0] v);
    @(posedge pclk);
    clr <= 1;
    @(posedge pclk);
    clr <= 0;
    evt <= v;
    @(posedge pclk);
    evt <= 0;
    repeat (6) @(posedge pclk);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20us;
    err_total++;
    conclude;
  end
  initial begin
    // falling edge at time zero so the asynchronous reset is really seen
    presetn <= 0;
    repeat (8) @(posedge pclk);
    chk({s3, s2, s1, s0}, 0, "reset vectors");
    presetn <= 1;
    apb(0, 12'h000, 0);
    chk(rd, 0, "ctrl reset");
    apb(0, 12'h00c, 0);
    chk(rd, 0, "mask reset");
    apb(1, 12'h00c, 32'h0000_fef7);
    apb(1, 12'h000, 32'h5);
    repeat (6) @(posedge pclk);
    chk({s3[6], s2[6], s1[6], s0[6]}, 4'h5, "run bits");
    ev(32'h3000_0000);
    chk({s3[5], s2[5], s1[5], s0[5]}, 4'h3, "pending bits");
    apb(1, 12'h010, 32'h2);
    repeat (6) @(posedge pclk);
    chk({s1[5], s0[5]}, 2'b01, "pending cleared");
    smode <= 4'h1;
    ev(32'h0300_0000);
    chk({seen[11], seen[4]}, 2'b01, "packet done");
    chk(irq, 0, "masked irq");
    ev(32'h0000_0007);
    chk(seen[14], 1, "busy on push");
    ev(32'h0064_7000);
    chk(seen[3:1], 3'b100, "ch0 done only");
    chk(seen[10:8], 3'b101, "ch1 completed");
    chk(seen[17:15], 3'b111, "ch2 stop");
    chk(irq, 1, "irq raised");
    apb(0, 12'h008, 0);
    chk(rd, 32'h759, "event status");
    repeat (6) @(posedge pclk);
    chk(irq, 0, "irq cleared");
    ev(32'h0000_0080);
    chk(s3[0], 1, "busy outstanding");
    ev(32'h0000_0800);
    chk(s3[0], 0, "busy retired");
    apb(1, 12'h014, 32'h8);
    repeat (6) @(posedge pclk);
    chk(s3[5], 1, "pending set");
    apb(0, 12'h02c, 0);
    chk(rd, 32'h20, "ch3 vector");
    apb(0, 12'h004, 0);
    chk(rd, 0, "busy register");
    apb(0, 12'h030, 0);
    chk(rd, 0, "unmapped read");
    chk(slv, 1, "unmapped error");
    conclude;
  end
endmodule
